// ==== verilog/brf_decode.sv ====
// Register file decoder: pointer, banks, general storage and program map
`timescale 1ns/100ps
module brf_decode
  import brf_pkg::*;
#(
  parameter int GP_DEPTH = 300
) (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire brf_pkg::brf_req_t req_i,
  input  wire logic [7:0]        ext_rdata_i,
  input  wire logic              fetch_req_i,
  input  wire logic [15:0]       fetch_pc_i,
  input  wire logic              infrared_vector_i,
  input  wire logic              sync_vector_i,
  input  wire logic              vec_req_i,
  input  wire logic [2:0]        vec_num_i,
  output brf_pkg::brf_ext_t      ext_req_o,
  output logic [7:0]             rdata_o,
  output logic                   rvalid_o,
  output logic                   access_err_o,
  output logic [7:0]             pointer_o,
  output logic [14:0]            fetch_addr_o,
  output logic                   fetch_valid_o,
  output logic                   fetch_fault_o,
  output logic [15:0]            vec_addr_o,
  output logic                   vec_valid_o,
  output logic                   start_o,
  output logic [15:0]            start_pc_o
);

  // Read source codes for the answer pipeline
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_RAM  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] SRC_RP   = 2'h3;

  // Reset released through two flops so all logic leaves reset together
  logic rst_s1_q, rst_n;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Effective 8-bit address from the access mode
  function automatic logic [7:0] resolve(input logic [1:0] mode, input logic [7:0] a, input logic [7:0] rp);
    if (mode == BRF_M_WORK) begin
      return {rp[7:4], a[3:0]};
    end
    return a;
  endfunction : resolve

  logic [7:0] rp_q, rp_d;
  brf_ext_t   ext_q, ext_d;
  logic [1:0] src_q, src_d;
  logic       rd_q, rd_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       err_q, err_d;
  logic [7:0] rp_cap_q, rp_cap_d;
  logic       ram_we, ram_re;
  logic [8:0] ram_addr;
  logic [7:0] ram_rdata;
  logic [7:0] eff;
  logic [3:0] bank;
  logic       in_bank;

  assign eff     = resolve(req_i.mode, req_i.addr, rp_q);
  assign bank    = rp_q[3:0];
  assign in_bank = (bank != 4'h0) && (eff <= BRF_BANK_TOP);

  // Decode one access per cycle into storage, pointer or forwarded target
  always_comb begin
    rp_d     = rp_q;
    ext_d    = '0;
    src_d    = SRC_NONE;
    rd_d     = 1'b0;
    err_d    = 1'b0;
    ram_we   = 1'b0;
    ram_re   = 1'b0;
    ram_addr = 9'h000;
    if (req_i.valid) begin
      rd_d = !req_i.write;
      if (req_i.mode == BRF_M_DIRECT && eff >= BRF_WREG_FIRST && eff <= BRF_GP_LAST) begin
        // Direct form of E0h-EFh is the working-register escape, so refuse it
        err_d = 1'b1;
      end else if (in_bank) begin
        if (brf_bank_gp(bank)) begin
          // Banks 4-7 sit after the standard bytes in the same array
          ram_addr = 9'(BRF_STD_GP_N) + {3'h0, 2'(bank - BRF_BANK_GP0), eff[3:0]};
          ram_we   = req_i.write;
          ram_re   = !req_i.write;
          src_d    = SRC_RAM;
        end else if (brf_bank_impl(bank)) begin
          ext_d.valid = 1'b1;
          ext_d.write = req_i.write;
          ext_d.space = BRF_S_BANK;
          ext_d.bank  = bank;
          ext_d.addr  = eff;
          ext_d.wdata = req_i.wdata;
          src_d       = SRC_EXT;
        end else begin
          // Missing bank: no storage touched, read answers zero
          err_d = 1'b1;
        end
      end else if (eff == BRF_RP_ADDR) begin
        if (req_i.write) begin
          rp_d = req_i.wdata;
        end
        src_d = SRC_RP;
      end else if (eff == BRF_PORT_LO || eff == BRF_PORT_HI) begin
        ext_d.valid = 1'b1;
        ext_d.write = req_i.write;
        ext_d.space = BRF_S_PORT;
        ext_d.addr  = eff;
        ext_d.wdata = req_i.wdata;
        src_d       = SRC_EXT;
      end else if (eff >= BRF_GP_FIRST && eff <= BRF_GP_LAST) begin
        ram_addr = {1'b0, eff - BRF_GP_FIRST};
        ram_we   = req_i.write;
        ram_re   = !req_i.write;
        src_d    = SRC_RAM;
      end else if (eff >= BRF_CTL_FIRST) begin
        ext_d.valid = 1'b1;
        ext_d.write = req_i.write;
        ext_d.space = BRF_S_CTRL;
        ext_d.addr  = eff;
        ext_d.wdata = req_i.wdata;
        src_d       = SRC_EXT;
      end else begin
        // 00h, 01h and F0h hold nothing
        err_d = 1'b1;
      end
    end
  end

  // Pointer copy for reads; the value read is the one before any write
  always_comb begin
    rp_cap_d  = rp_q;
  end

  // Second answer stage picks the source caught one cycle earlier
  always_comb begin
    rvalid_d = rd_q;
    unique case (src_q)
      SRC_RAM: rdata_d = ram_rdata;
      SRC_EXT: rdata_d = ext_rdata_i;
      SRC_RP:  rdata_d = rp_cap_q;
      default: rdata_d = 8'h00;
    endcase
    if (!rd_q) begin
      rdata_d = rdata_q;
    end
  end

  // Registers only; pointer has no documented reset value, zero is used
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rp_q      <= BRF_RP_RESET;
      ext_q     <= '0;
      src_q     <= SRC_NONE;
      rd_q      <= 1'b0;
      err_q     <= 1'b0;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
      rp_cap_q  <= 8'h00;
    end else begin
      rp_q      <= rp_d;
      ext_q     <= ext_d;
      src_q     <= src_d;
      rd_q      <= rd_d;
      err_q     <= err_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      rp_cap_q  <= rp_cap_d;
    end
  end

  // Storage for standard and banked general bytes
  brf_gp_ram #(
    .DEPTH (GP_DEPTH),
    .AW    (9)
  ) u_gp_ram (
    .clock_i (clock_i),
    .we_i    (ram_we),
    .re_i    (ram_re),
    .addr_i  (ram_addr),
    .wdata_i (req_i.wdata),
    .rdata_o (ram_rdata)
  );

  // Program memory map
  brf_prog_map u_prog_map (
    .clock_i           (clock_i),
    .rst_n_i           (rst_n),
    .fetch_req_i       (fetch_req_i),
    .fetch_pc_i        (fetch_pc_i),
    .infrared_vector_i (infrared_vector_i),
    .sync_vector_i     (sync_vector_i),
    .vec_req_i         (vec_req_i),
    .vec_num_i         (vec_num_i),
    .fetch_addr_o      (fetch_addr_o),
    .fetch_valid_o     (fetch_valid_o),
    .fetch_fault_o     (fetch_fault_o),
    .vec_addr_o        (vec_addr_o),
    .vec_valid_o       (vec_valid_o),
    .start_o           (start_o),
    .start_pc_o        (start_pc_o)
  );

  assign ext_req_o    = ext_q;
  assign rdata_o      = rdata_q;
  assign rvalid_o     = rvalid_q;
  assign access_err_o = err_q;
  assign pointer_o    = rp_q;

  default clocking dec_cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  port_forward_a: assert property (req_i.valid && req_i.mode != BRF_M_WORK && req_i.addr inside {8'h02, 8'h03}
                                   && (rp_q[3:0] == 4'h0 || req_i.addr > 8'h0F)
                                   |=> ext_q.valid && ext_q.space == BRF_S_PORT)
    else $error("port register access not forwarded");
  gp_index_a: assert property (req_i.valid && req_i.mode == BRF_M_INDIRECT && req_i.addr inside {[8'h10:8'hEF]}
                               |-> ram_addr == {1'b0, req_i.addr} - 9'd4)
    else $error("general byte index wrong");
  ctrl_forward_a: assert property (req_i.valid && req_i.mode != BRF_M_WORK && req_i.addr >= 8'hF1
                                   && req_i.addr != 8'hFD |=> ext_q.valid && ext_q.space == BRF_S_CTRL)
    else $error("control register access not forwarded");
  reserved_quiet_a: assert property (req_i.valid && req_i.mode == BRF_M_INDIRECT && req_i.addr == 8'hF0
                                     |-> !ram_we && !ram_re ##1 !ext_q.valid && err_q)
    else $error("reserved location acted on");
  direct_escape_a: assert property (req_i.valid && req_i.mode == BRF_M_DIRECT && req_i.addr inside {[8'hE0:8'hEF]}
                                    |-> !ram_we ##1 err_q && !ext_q.valid)
    else $error("direct access reached E0h-EFh");
  pointer_write_a: assert property (req_i.valid && req_i.write && req_i.mode != BRF_M_WORK && req_i.addr == 8'hFD
                                    |=> rp_q == $past(req_i.wdata))
    else $error("pointer not updated");
  working_group_a: assert property (req_i.valid && req_i.mode == BRF_M_WORK && rp_q[7:4] == 4'h5
                                    |-> eff == {4'h5, req_i.addr[3:0]})
    else $error("working group base wrong");
  bank_gp_a: assert property (req_i.valid && rp_q[3:0] == 4'h6 && req_i.mode == BRF_M_INDIRECT
                              && req_i.addr <= 8'h0F |-> ram_addr == 9'd268 + {5'h00, req_i.addr[3:0]})
    else $error("bank 6 byte index wrong");
  missing_bank_a: assert property (req_i.valid && rp_q[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hD, 4'hE}
                                   && req_i.mode == BRF_M_INDIRECT && req_i.addr <= 8'h0F
                                   |-> !ram_we ##1 !ext_q.valid && err_q)
    else $error("unimplemented bank disturbed state");
  read_latency_a: assert property (req_i.valid && !req_i.write |=> ##1 rvalid_q)
    else $error("read answer not two cycles later");

  bank_read_c: cover property (req_i.valid && !req_i.write && in_bank ##2 rvalid_q);
  ptr_write_c: cover property (req_i.valid && req_i.write && eff == BRF_RP_ADDR);
  escape_c:    cover property (err_q);

endmodule : brf_decode

// ==== include/brf_pkg.sv ====
// Package of register file and program memory map constants and carriers
package brf_pkg;

  // Standard register file landmarks
  localparam logic [7:0] BRF_PORT_LO    = 8'h02;
  localparam logic [7:0] BRF_PORT_HI    = 8'h03;
  localparam logic [7:0] BRF_GP_FIRST   = 8'h04;
  localparam logic [7:0] BRF_GP_LAST    = 8'hEF;
  localparam logic [7:0] BRF_WREG_FIRST = 8'hE0;
  localparam logic [7:0] BRF_RSVD_F0    = 8'hF0;
  localparam logic [7:0] BRF_CTL_FIRST  = 8'hF1;
  localparam logic [7:0] BRF_RP_ADDR    = 8'hFD;
  localparam logic [7:0] BRF_RP_RESET   = 8'h00;
  localparam logic [7:0] BRF_BANK_TOP   = 8'h0F;
  localparam int         BRF_STD_GP_N   = 236;
  localparam int         BRF_BANK_GP_N  = 64;
  localparam int         BRF_GP_DEPTH   = BRF_STD_GP_N + BRF_BANK_GP_N;
  localparam logic [3:0] BRF_BANK_GP0   = 4'h4;

  // Program memory landmarks
  localparam int          BRF_PM_BYTES  = 32768;
  localparam int          BRF_VEC_N     = 6;
  localparam logic [15:0] BRF_RESTART   = 16'h000C;
  localparam logic [2:0]  BRF_VEC_IR    = 3'h0;
  localparam logic [2:0]  BRF_VEC_SYNC  = 3'h1;

  // Access modes from the core
  localparam logic [1:0] BRF_M_DIRECT   = 2'h0;
  localparam logic [1:0] BRF_M_WORK     = 2'h1;
  localparam logic [1:0] BRF_M_INDIRECT = 2'h2;

  // Targets of forwarded accesses
  localparam logic [1:0] BRF_S_PORT     = 2'h0;
  localparam logic [1:0] BRF_S_CTRL     = 2'h1;
  localparam logic [1:0] BRF_S_BANK     = 2'h2;

  // Register access request from the core
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] mode;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brf_req_t;

  // Access forwarded to ports, control registers or peripheral banks
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] space;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } brf_ext_t;

  // Banks that carry registers at all
  function automatic logic brf_bank_impl(input logic [3:0] b);
    return (b inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hF});
  endfunction : brf_bank_impl

  // Banks that hold plain storage
  function automatic logic brf_bank_gp(input logic [3:0] b);
    return (b >= 4'h4) && (b <= 4'h7);
  endfunction : brf_bank_gp

endpackage : brf_pkg

// ==== verilog/brf_gp_ram.sv ====
// General-purpose register storage with registered read
`timescale 1ns/100ps
module brf_gp_ram #(
  parameter int DEPTH = 300,
  parameter int AW    = 9
) (
  input  wire logic          clock_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);

  // Contents survive reset, as the core expects of general registers
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;

  // Single port, write and read never in the same cycle from the decoder
  always_ff @(posedge clock_i) begin
    if (we_i && (32'(addr_i) < DEPTH)) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (re_i && (32'(addr_i) < DEPTH)) begin
      rdata_q <= mem_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;

endmodule : brf_gp_ram

// ==== verilog/brf_prog_map.sv ====
// Program memory decode: fetch range, vector addresses, restart address
`timescale 1ns/100ps
module brf_prog_map
  import brf_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        fetch_req_i,
  input  wire logic [15:0] fetch_pc_i,
  input  wire logic        infrared_vector_i,
  input  wire logic        sync_vector_i,
  input  wire logic        vec_req_i,
  input  wire logic [2:0]  vec_num_i,
  output logic      [14:0] fetch_addr_o,
  output logic             fetch_valid_o,
  output logic             fetch_fault_o,
  output logic      [15:0] vec_addr_o,
  output logic             vec_valid_o,
  output logic             start_o,
  output logic      [15:0] start_pc_o
);

  typedef enum logic [1:0] {
    ST_RESTART = 2'b01,
    ST_RUN     = 2'b10
  } brf_pm_state_t;

  brf_pm_state_t state_q, state_d;
  logic [14:0]   faddr_q, faddr_d;
  logic          fvalid_q, fvalid_d, ffault_q, ffault_d;
  logic [15:0]   vaddr_q, vaddr_d, spc_q, spc_d;
  logic          vvalid_q, vvalid_d, start_q, start_d;

  // Next values: one start pulse after reset, then fetch and vector decode
  always_comb begin
    state_d  = state_q;
    start_d  = 1'b0;
    spc_d    = spc_q;
    fvalid_d = 1'b0;
    ffault_d = 1'b0;
    faddr_d  = faddr_q;
    vvalid_d = 1'b0;
    vaddr_d  = vaddr_q;
    unique case (state_q)
      ST_RESTART: begin
        start_d = 1'b1;
        spc_d   = BRF_RESTART;
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (fetch_req_i) begin
          // Anything at or above 32 KB is refused, not wrapped
          fvalid_d = (32'(fetch_pc_i) < BRF_PM_BYTES);
          ffault_d = !(32'(fetch_pc_i) < BRF_PM_BYTES);
          faddr_d  = fetch_pc_i[14:0];
        end
        // Infrared ahead of sync; both wired to fixed slots
        if (infrared_vector_i) begin
          vvalid_d = 1'b1;
          vaddr_d  = {12'h000, BRF_VEC_IR, 1'b0};
        end else if (sync_vector_i) begin
          vvalid_d = 1'b1;
          vaddr_d  = {12'h000, BRF_VEC_SYNC, 1'b0};
        end else if (vec_req_i && (32'(vec_num_i) < BRF_VEC_N)) begin
          vvalid_d = 1'b1;
          vaddr_d  = {12'h000, vec_num_i, 1'b0};
        end
      end
      default: state_d = ST_RESTART;
    endcase
  end

  // Registers only
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= ST_RESTART;
      start_q  <= 1'b0;
      spc_q    <= 16'h0000;
      fvalid_q <= 1'b0;
      ffault_q <= 1'b0;
      faddr_q  <= 15'h0000;
      vvalid_q <= 1'b0;
      vaddr_q  <= 16'h0000;
    end else begin
      state_q  <= state_d;
      start_q  <= start_d;
      spc_q    <= spc_d;
      fvalid_q <= fvalid_d;
      ffault_q <= ffault_d;
      faddr_q  <= faddr_d;
      vvalid_q <= vvalid_d;
      vaddr_q  <= vaddr_d;
    end
  end

  assign fetch_addr_o  = faddr_q;
  assign fetch_valid_o = fvalid_q;
  assign fetch_fault_o = ffault_q;
  assign vec_addr_o    = vaddr_q;
  assign vec_valid_o   = vvalid_q;
  assign start_o       = start_q;
  assign start_pc_o    = spc_q;

  default clocking pm_cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  restart_pc_a: assert property (start_q |-> spc_q == 16'h000C)
    else $error("restart address is not 000Ch");
  vector_area_a: assert property (vvalid_q |-> vaddr_q < 16'h000C)
    else $error("vector address outside the reserved area");
  infrared_slot_a: assert property (state_q == ST_RUN && infrared_vector_i |=> vvalid_q && vaddr_q == 16'h0000)
    else $error("infrared request did not select the first vector");
  sync_slot_a: assert property (state_q == ST_RUN && !infrared_vector_i && sync_vector_i
                                |=> vvalid_q && vaddr_q == 16'h0002)
    else $error("sync request did not select the second vector");
  fetch_range_a: assert property (state_q == ST_RUN && fetch_req_i && fetch_pc_i[15] |=> ffault_q && !fvalid_q)
    else $error("fetch beyond 32 KB was accepted");
  start_once_c: cover property (start_q ##1 !start_q);

endmodule : brf_prog_map

// ==== verification/brf_periph_model.sv ====
// Peripheral-side responder for accesses forwarded by the register decoder
`timescale 1ns/100ps
module brf_periph_model
  import brf_pkg::*;
(
  input  wire logic              clock_i,
  input  wire brf_pkg::brf_ext_t ext_req_i,
  output logic [7:0]             ext_rdata_o
);
  logic [7:0]  mem [0:16383];
  logic [7:0]  last_q = 8'h00;
  logic [13:0] idx;

  // Each space and bank keeps bytes of its own, so a wrong space or bank reads back wrong
  assign idx = {ext_req_i.space, ext_req_i.bank, ext_req_i.addr};
  // Data only while a read is presented; otherwise a value that flips every cycle
  assign ext_rdata_o = (ext_req_i.valid && !ext_req_i.write) ? mem[idx] : ~last_q;

  // Writes land at the edge; the driven value is kept for the idle pattern
  always_ff @(posedge clock_i) begin
    if (ext_req_i.valid && ext_req_i.write) begin
      mem[idx] <= ext_req_i.wdata;
    end
    last_q <= ext_rdata_o;
  end
endmodule : brf_periph_model

// ==== verification/test_banked_register_file_decode.sv ====
// Self-checking bench for the register file and program memory decoder
`timescale 1ns/100ps
module test_banked_register_file_decode;
  import brf_pkg::*;

  logic        clock_i;
  logic        rstn_i;
  brf_req_t    req_i;
  logic [7:0]  ext_rdata_i;
  logic        fetch_req_i;
  logic [15:0] fetch_pc_i;
  logic        infrared_vector_i;
  logic        sync_vector_i;
  logic        vec_req_i;
  logic [2:0]  vec_num_i;
  brf_ext_t    ext_req_o;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic        access_err_o;
  logic [7:0]  pointer_o;
  logic [14:0] fetch_addr_o;
  logic        fetch_valid_o;
  logic        fetch_fault_o;
  logic [15:0] vec_addr_o;
  logic        vec_valid_o;
  logic        start_o;
  logic [15:0] start_pc_o;
  int          err_count;
  int          compares;
  logic [31:0] seed_q;
  logic [7:0]  rd;
  logic        rv;
  logic        er;
  brf_ext_t    ex;
  logic [7:0]  exp_std [0:255];
  logic [7:0]  a;
  logic [7:0]  d;
  logic [1:0]  k;
  localparam logic [15:0] PCS [6] = '{16'h0000, 16'h000C, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h0100};

  brf_decode #(.GP_DEPTH(BRF_GP_DEPTH)) uut (
    .clock_i(clock_i), .rstn_i(rstn_i), .req_i(req_i), .ext_rdata_i(ext_rdata_i),
    .fetch_req_i(fetch_req_i), .fetch_pc_i(fetch_pc_i), .infrared_vector_i(infrared_vector_i),
    .sync_vector_i(sync_vector_i), .vec_req_i(vec_req_i), .vec_num_i(vec_num_i), .ext_req_o(ext_req_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .access_err_o(access_err_o), .pointer_o(pointer_o),
    .fetch_addr_o(fetch_addr_o), .fetch_valid_o(fetch_valid_o), .fetch_fault_o(fetch_fault_o),
    .vec_addr_o(vec_addr_o), .vec_valid_o(vec_valid_o), .start_o(start_o), .start_pc_o(start_pc_o));

  brf_periph_model periph (.clock_i(clock_i), .ext_req_i(ext_req_o), .ext_rdata_o(ext_rdata_i));

  // Free-running system clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // Repeatable pseudo-random bytes
  function automatic logic [7:0] rnd8();
    seed_q = seed_q ^ (seed_q << 13);
    seed_q = seed_q ^ (seed_q >> 17);
    seed_q = seed_q ^ (seed_q << 5);
    return seed_q[7:0];
  endfunction : rnd8

  // Bank class: 0 plain storage, 1 peripheral bank, 2 no registers
  function automatic logic [1:0] bank_kind(input logic [3:0] b);
    if (b inside {4'h4, 4'h5, 4'h6, 4'h7}) return 2'h0;
    if (b inside {4'hA, 4'hB, 4'hC, 4'hF}) return 2'h1;
    return 2'h2;
  endfunction : bank_kind

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One access; the flag and forwarded copy are caught one cycle after taking, the answer two
  task automatic acc(input logic w, input logic [1:0] m, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clock_i);
    req_i <= '{valid: 1'b1, write: w, mode: m, addr: ad, wdata: wd};
    @(posedge clock_i);
    req_i.valid <= 1'b0;
    #1;
    er = access_err_o;
    ex = ext_req_o;
    @(posedge clock_i);
    #1;
    rv = rvalid_o;
    rd = rdata_o;
  endtask : acc

  task automatic rdchk(input logic [1:0] m, input logic [7:0] ad, input logic e, input logic [7:0] ed);
    acc(1'b0, m, ad, 8'h00);
    chk("refusal flag", {15'h0000, e}, {15'h0000, er});
    chk("read valid", 16'h0001, {15'h0000, rv});
    chk("read data", {8'h00, ed}, {8'h00, rd});
  endtask : rdchk

  task automatic setp(input logic [7:0] p);
    acc(1'b1, BRF_M_DIRECT, BRF_RP_ADDR, p);
    chk("pointer", {8'h00, p}, {8'h00, pointer_o});
  endtask : setp

  // Fetch and vector request together; vs is infrared, sync, numbered request
  task automatic prog(input logic f, input logic [15:0] pc, input logic [2:0] vs, input logic [2:0] n);
    logic        vx;
    logic [15:0] va;
    vx = vs[2] | vs[1] | (vs[0] & (n < 3'h6));
    va = vs[2] ? 16'h0000 : (vs[1] ? 16'h0002 : {12'h000, n, 1'b0});
    @(posedge clock_i);
    fetch_req_i <= f;
    fetch_pc_i <= pc;
    {infrared_vector_i, sync_vector_i, vec_req_i} <= vs;
    vec_num_i <= n;
    @(posedge clock_i);
    fetch_req_i <= 1'b0;
    {infrared_vector_i, sync_vector_i, vec_req_i} <= 3'h0;
    #1;
    chk("fetch valid", {15'h0000, f & ~pc[15]}, {15'h0000, fetch_valid_o});
    chk("fetch fault", {15'h0000, f & pc[15]}, {15'h0000, fetch_fault_o});
    if (f && !pc[15]) chk("fetch address", {1'b0, pc[14:0]}, {1'b0, fetch_addr_o});
    chk("vector valid", {15'h0000, vx}, {15'h0000, vec_valid_o});
    if (vx) chk("vector address", va, vec_addr_o);
  endtask : prog

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Watchdog well beyond the roughly 1,800 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    complete_run();
  end

  initial begin
    rstn_i = 1'b0;
    req_i = '0;
    {fetch_req_i, infrared_vector_i, sync_vector_i, vec_req_i} = 4'h0;
    fetch_pc_i = 16'h0000;
    vec_num_i = 3'h0;
    err_count = 0;
    compares = 0;
    seed_q = 32'h0000_5099;
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk("start pulse", 16'h0001, {15'h0000, start_o});
    chk("start address", 16'h000C, start_pc_o);
    chk("pointer after reset", 16'h0000, {8'h00, pointer_o});
    $display("test reset done");
    // Pointer written and read back through its own address
    setp(8'h3C);
    rdchk(BRF_M_DIRECT, BRF_RP_ADDR, 1'b0, 8'h3C);
    setp(8'h00);
    $display("test pointer done");
    // Every general byte, direct or indirect at random, top sixteen indirect only
    for (int j = 4; j < 240; j++) begin
      exp_std[j] = rnd8();
      acc(1'b1, (j >= 224 || rnd8() > 8'h7F) ? BRF_M_INDIRECT : BRF_M_DIRECT, 8'(j), exp_std[j]);
    end
    for (int j = 4; j < 240; j++) begin
      rdchk((j >= 224) ? BRF_M_INDIRECT : BRF_M_DIRECT, 8'(j), 1'b0, exp_std[j]);
    end
    $display("test general storage done");
    // Working group E and group 5 through the pointer's upper nibble
    setp(8'hE0);
    for (int x = 0; x < 16; x++) rdchk(BRF_M_WORK, 8'(x), 1'b0, exp_std[8'hE0 + x]);
    setp(8'h50);
    rdchk(BRF_M_WORK, 8'h07, 1'b0, exp_std[8'h57]);
    setp(8'h00);
    // Direct access to the top sixteen is refused and stores nothing
    a = 8'hE0 + (rnd8() & 8'h0F);
    acc(1'b1, BRF_M_DIRECT, a, ~exp_std[a]);
    chk("direct write flag", 16'h0001, {15'h0000, er});
    rdchk(BRF_M_DIRECT, a, 1'b1, 8'h00);
    rdchk(BRF_M_INDIRECT, a, 1'b0, exp_std[a]);
    // Reserved standard locations
    for (int i = 0; i < 3; i++) rdchk(BRF_M_DIRECT, (i == 2) ? BRF_RSVD_F0 : 8'(i), 1'b1, 8'h00);
    $display("test refusals done");
    // Port and control addresses go out, with data round-tripped through the peripheral side
    for (int i = 0; i < 17; i++) begin
      a = (i < 2) ? 8'(2 + i) : 8'(8'hF1 + i - 2);
      if (a == BRF_RP_ADDR) continue;
      d = rnd8();
      acc(1'b1, BRF_M_DIRECT, a, d);
      chk("forward valid", 16'h0001, {15'h0000, ex.valid});
      chk("forward space", {14'h0000, (i < 2) ? BRF_S_PORT : BRF_S_CTRL}, {14'h0000, ex.space});
      chk("forward address", {8'h00, a}, {8'h00, ex.addr});
      rdchk(BRF_M_DIRECT, a, 1'b0, d);
    end
    $display("test ports and control done");
    // Every bank number at the boundary location 0Fh
    for (int b = 1; b < 16; b++) begin
      k = bank_kind(4'(b));
      d = {4'(b), 4'h6};
      setp({4'h0, 4'(b)});
      acc(1'b1, BRF_M_INDIRECT, 8'h0F, d);
      chk("bank refusal", {15'h0000, k == 2'h2}, {15'h0000, er});
      chk("bank forward", {15'h0000, k == 2'h1}, {15'h0000, ex.valid});
      if (k == 2'h1) chk("bank number", {10'h000, BRF_S_BANK, 4'(b)}, {10'h000, ex.space, ex.bank});
      rdchk(BRF_M_WORK, 8'h0F, k == 2'h2, (k == 2'h2) ? 8'h00 : d);
    end
    for (int b = 4; b < 8; b++) begin
      setp(8'(b));
      rdchk(BRF_M_DIRECT, 8'h0F, 1'b0, {4'(b), 4'h6});
    end
    setp(8'h00);
    rdchk(BRF_M_DIRECT, 8'h0F, 1'b0, exp_std[8'h0F]);
    $display("test banks done");
    // Fetch range edges plus a random address
    for (int i = 0; i < 6; i++) prog(1'b1, PCS[i], 3'h0, 3'h0);
    prog(1'b1, {rnd8(), rnd8()}, 3'h0, 3'h0);
    // Fixed vectors, their priority, and every vector number
    prog(1'b0, 16'h0000, 3'h4, 3'h0);
    prog(1'b0, 16'h0000, 3'h2, 3'h0);
    prog(1'b0, 16'h0000, 3'h7, 3'h5);
    prog(1'b0, 16'h0000, 3'h3, 3'h4);
    for (int n = 0; n < 8; n++) prog(1'b0, 16'h0000, 3'h1, 3'(n));
    $display("test program map done");
    complete_run();
  end
endmodule : test_banked_register_file_decode
